// File: inc/host_event_pkg.sv
// Shared constants for the host port event status block
package host_event_pkg;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] PORT_STEP = 10'h200;
  localparam logic [9:0] STATUS_OFS = 10'h140;
  localparam logic [9:0] ENABLE_OFS = 10'h150;
  localparam logic [9:0] SPEED_OFS = 10'h154;
  localparam logic [9:0] ROLE_OFS = 10'h004;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned ATTACH_BIT = 4;
  localparam int unsigned DETACH_BIT = 3;
  localparam int unsigned WAKEUP_BIT = 2;
  localparam int unsigned GOOD_CHIRP_BIT = 1;
  localparam int unsigned BAD_CHIRP_BIT = 0;
  localparam int unsigned HOST_ROLE_BIT = 0;
  localparam logic [7:0] EVENT_MASK = 8'h1F;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic ROLE_RESET = 1'b0;
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_RESET = 2'h1;

endpackage

// File: design/port_event_logic.sv
// Event status, enable and speed state of one host port
`timescale 1ns/1ns
module port_event_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_mode,
  input wire logic wr_status,
  input wire logic wr_enable,
  input wire logic [7:0] wdata,
  input wire logic attach_pulse,
  input wire logic detach_pulse,
  input wire logic wakeup_pulse,
  input wire logic good_chirp_pulse,
  input wire logic bad_chirp_pulse,
  input wire logic bus_reset,
  output logic [7:0] status,
  output logic [7:0] enable,
  output logic [1:0] port_speed,
  output logic irq
);

  logic [7:0] next_status;
  logic [7:0] next_enable;
  logic [1:0] next_speed;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_status = status;
    next_enable = enable;
    next_speed = port_speed;
    if (wr_status && host_mode) begin // R9
      next_status = status & ~wdata; // R1
    end
    next_status[host_event_pkg::ATTACH_BIT] = next_status[host_event_pkg::ATTACH_BIT] | attach_pulse; // R2
    next_status[host_event_pkg::DETACH_BIT] = next_status[host_event_pkg::DETACH_BIT] | detach_pulse; // R3
    next_status[host_event_pkg::WAKEUP_BIT] = next_status[host_event_pkg::WAKEUP_BIT] | wakeup_pulse; // R4
    next_status[host_event_pkg::GOOD_CHIRP_BIT] = next_status[host_event_pkg::GOOD_CHIRP_BIT]
      | good_chirp_pulse; // R5
    next_status[host_event_pkg::BAD_CHIRP_BIT] = next_status[host_event_pkg::BAD_CHIRP_BIT] | bad_chirp_pulse; // R6
    next_status = next_status & host_event_pkg::EVENT_MASK; // R14
    if (wr_enable) begin
      next_enable = wdata & host_event_pkg::EVENT_MASK;
    end
    if (bus_reset && status[host_event_pkg::GOOD_CHIRP_BIT]) begin
      next_speed = host_event_pkg::SPEED_HS; // R7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= host_event_pkg::STATUS_RESET;
      enable <= host_event_pkg::ENABLE_RESET;
      port_speed <= host_event_pkg::SPEED_RESET;
    end else begin
      status <= next_status;
      enable <= next_enable;
      port_speed <= next_speed;
    end
  end

  assign irq = |(status & enable); // R13

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  attach_sets_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    attach_pulse |=> status[host_event_pkg::ATTACH_BIT])
    else $error("attach event not latched");

  set_beats_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (wr_status && host_mode && wdata[host_event_pkg::DETACH_BIT] && detach_pulse)
    |=> status[host_event_pkg::DETACH_BIT])
    else $error("detach event lost under clear");

  clear_one_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (wr_status && host_mode && wdata[host_event_pkg::WAKEUP_BIT] && !wakeup_pulse)
    |=> !status[host_event_pkg::WAKEUP_BIT])
    else $error("wakeup bit not cleared by one");

  zero_keeps_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (wr_status && !wdata[host_event_pkg::BAD_CHIRP_BIT] && status[host_event_pkg::BAD_CHIRP_BIT])
    |=> status[host_event_pkg::BAD_CHIRP_BIT])
    else $error("bad chirp bit lost on zero write");

  guest_no_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (wr_status && !host_mode) |=> ((status & $past(status)) == $past(status)))
    else $error("status cleared outside host mode");

  chirp_speed_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    (bus_reset && status[host_event_pkg::GOOD_CHIRP_BIT]) |=> (port_speed == host_event_pkg::SPEED_HS))
    else $error("speed not high after good chirp");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    status[7:5] == 3'h0 ##0 enable[7:5] == 3'h0)
    else $error("reserved bits not zero");

  good_chirp_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    good_chirp_pulse |=> status[host_event_pkg::GOOD_CHIRP_BIT])
    else $error("good chirp not latched");

endmodule

// File: design/host_port_event_status.sv
// Host port event status registers for two ports behind an Avalon-MM slave
// ---------------------------------------------------------------
// What this block does
// [R1] Writing one to an event bit clears it, writing zero keeps it, and a read returns the latched events.
// [R2] A cable attach on the host port sets event bit 4.
// [R3] A cable detach on the host port sets event bit 3.
// [R4] A remote wakeup from a suspended device sets event bit 2.
// [R5] A valid chirp response from the device sets event bit 1.
// [R6] An erroneous chirp from the device sets event bit 0.
// [R7] During bus reset a set good chirp bit loads the port speed with high speed (00b).
// [R8] Software clears the good chirp bit on every detach so a stale value cannot pick high speed.
// [R9] Event bits 4 to 0 can be neither read nor cleared unless the host role bit is one.
// [R10] Before leaving host mode software clears the event bits and then drops the enables.
// [R11] On entering host mode software clears the event bits before setting the enables.
// [R12] Each of the two ports has its own event status register at 140h from a port base of 000h or 200h.
// [R13] The active-low interrupt output is asserted while any event bit and its enable are both set.
// [R14] Reserved bits 7 to 5 read as zero and ignore writes.
// ---------------------------------------------------------------
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module host_port_event_status #(
  parameter int unsigned NUM_PORTS = host_event_pkg::NUM_PORTS,
  parameter int unsigned ADDR_W = host_event_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NUM_PORTS-1:0] cable_attach_event,
  input wire logic [NUM_PORTS-1:0] cable_detach_event,
  input wire logic [NUM_PORTS-1:0] remote_wakeup_event,
  input wire logic [NUM_PORTS-1:0] good_chirp_event,
  input wire logic [NUM_PORTS-1:0] bad_chirp_event,
  input wire logic [NUM_PORTS-1:0] bus_reset_active,
  output logic [NUM_PORTS-1:0][1:0] port_speed_field,
  output logic host_role_bit,
  output logic irq_out_n
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (NUM_PORTS < 1 || NUM_PORTS > 2 || ADDR_W != 10) begin : g_bad_param
    $error("port count must be 1 or 2 and address width 10");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [9:0] addr, input int unsigned port, input logic [9:0] ofs);
    logic [9:0] base;
    base = port[0] ? host_event_pkg::PORT_STEP : 10'h000;
    return addr == (base + ofs); // R12
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic next_role;
  logic req;
  logic wr_lane;
  logic [7:0] wbyte;

  assign req = read | write;
  assign wr_lane = write & ack & byteenable[0];
  assign wbyte = writedata[7:0];
  assign waitrequest = req & ~ack;

  // ---------------------------------------------------------------
  // Per-port state
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0][7:0] status;
  logic [NUM_PORTS-1:0][7:0] enable;
  logic [NUM_PORTS-1:0] irq;
  logic [NUM_PORTS-1:0] wr_status;
  logic [NUM_PORTS-1:0] wr_enable;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign wr_status[p] = wr_lane & hit(address, p, host_event_pkg::STATUS_OFS);
    assign wr_enable[p] = wr_lane & hit(address, p, host_event_pkg::ENABLE_OFS);

    port_event_logic u_port (
      .clk(clk),
      .rst_n(rst_sync_n),
      .host_mode(host_role_bit),
      .wr_status(wr_status[p]),
      .wr_enable(wr_enable[p]),
      .wdata(wbyte),
      .attach_pulse(cable_attach_event[p]),
      .detach_pulse(cable_detach_event[p]),
      .wakeup_pulse(remote_wakeup_event[p]),
      .good_chirp_pulse(good_chirp_event[p]),
      .bad_chirp_pulse(bad_chirp_event[p]),
      .bus_reset(bus_reset_active[p]),
      .status(status[p]),
      .enable(enable[p]),
      .port_speed(port_speed_field[p]),
      .irq(irq[p])
    );
  end

  // ---------------------------------------------------------------
  // Next bus state
  // ---------------------------------------------------------------
  always_comb begin
    next_ack = req & ~ack;
    next_role = host_role_bit;
    next_readdata = readdata;
    if (wr_lane && hit(address, 0, host_event_pkg::ROLE_OFS)) begin
      next_role = wbyte[host_event_pkg::HOST_ROLE_BIT];
    end
    if (read && !ack) begin
      next_readdata = 32'h0000_0000;
      if (hit(address, 0, host_event_pkg::ROLE_OFS)) begin
        next_readdata[host_event_pkg::HOST_ROLE_BIT] = host_role_bit;
      end
      for (int unsigned p = 0; p < NUM_PORTS; p++) begin
        if (hit(address, p, host_event_pkg::STATUS_OFS) && host_role_bit) begin // R9
          next_readdata[7:0] = status[p]; // R1
        end
        if (hit(address, p, host_event_pkg::ENABLE_OFS)) begin
          next_readdata[7:0] = enable[p];
        end
        if (hit(address, p, host_event_pkg::SPEED_OFS)) begin
          next_readdata[1:0] = port_speed_field[p];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack <= 1'b0;
      host_role_bit <= host_event_pkg::ROLE_RESET;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      host_role_bit <= next_role;
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  assign irq_out_n = ~(|irq); // R13

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  one_wait_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ($rose(req) && !ack) |-> waitrequest ##1 !waitrequest)
    else $error("answer not after one wait cycle");

  guest_read_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R9
    (read && !waitrequest && !host_role_bit && hit(address, 0, host_event_pkg::STATUS_OFS)
    && $stable(host_role_bit)) |-> readdata == 32'h0000_0000)
    else $error("status readable outside host mode");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (read && !ack && host_role_bit && hit(address, 0, host_event_pkg::STATUS_OFS))
    |=> readdata[7:0] == $past(status[0]))
    else $error("status read value wrong");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R13
    (|(status[0] & enable[0])) |-> !irq_out_n)
    else $error("interrupt not asserted");

  irq_quiet_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R13
    (status[0] & enable[0]) == 8'h00 && (NUM_PORTS == 1 || (status[NUM_PORTS-1] & enable[NUM_PORTS-1]) == 8'h00)
    |-> irq_out_n)
    else $error("interrupt with nothing pending");

  second_port_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R12
    (NUM_PORTS == 2 && write && !waitrequest && byteenable[0]
    && address == host_event_pkg::STATUS_OFS + host_event_pkg::PORT_STEP) |-> wr_status[NUM_PORTS-1])
    else $error("second port status not decoded");

  ack_follows_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (req && !ack) |=> ack)
    else $error("request not answered");

  ack_idle_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !req |=> !ack)
    else $error("answer without request");

  ack_single_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ack |=> !ack)
    else $error("answer held too long");

  readdata_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    !(read && !ack) |=> $stable(readdata))
    else $error("read data changed without a read");

  upper_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R14
    readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  guest_read1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R9
    (read && !waitrequest && !host_role_bit && hit(address, 1, host_event_pkg::STATUS_OFS)
    && $stable(host_role_bit)) |-> readdata == 32'h0000_0000)
    else $error("second port status readable outside host mode");

  status_read1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (NUM_PORTS == 2 && read && !ack && host_role_bit && hit(address, 1, host_event_pkg::STATUS_OFS))
    |=> readdata[7:0] == $past(status[NUM_PORTS-1]))
    else $error("second port status read value wrong");

  enable_read_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R13
    (read && !ack && hit(address, 0, host_event_pkg::ENABLE_OFS)) |=> readdata[7:0] == $past(enable[0]))
    else $error("enable read value wrong");

  enable_read1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R13
    (NUM_PORTS == 2 && read && !ack && hit(address, 1, host_event_pkg::ENABLE_OFS))
    |=> readdata[7:0] == $past(enable[NUM_PORTS-1]))
    else $error("second port enable read value wrong");

  speed_read_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R7
    (read && !ack && hit(address, 0, host_event_pkg::SPEED_OFS))
    |=> readdata == {30'h0, $past(port_speed_field[0])})
    else $error("speed read value wrong");

  speed_read1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R7
    (NUM_PORTS == 2 && read && !ack && hit(address, 1, host_event_pkg::SPEED_OFS))
    |=> readdata == {30'h0, $past(port_speed_field[NUM_PORTS-1])})
    else $error("second port speed read value wrong");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R12
    (read && !ack && !hit(address, 0, host_event_pkg::ROLE_OFS)
    && !hit(address, 0, host_event_pkg::STATUS_OFS) && !hit(address, 1, host_event_pkg::STATUS_OFS)
    && !hit(address, 0, host_event_pkg::ENABLE_OFS) && !hit(address, 1, host_event_pkg::ENABLE_OFS)
    && !hit(address, 0, host_event_pkg::SPEED_OFS) && !hit(address, 1, host_event_pkg::SPEED_OFS))
    |=> readdata == 32'h0000_0000)
    else $error("unmapped address read not zero");

  role_write_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R9
    (write && ack && byteenable[0] && hit(address, 0, host_event_pkg::ROLE_OFS))
    |=> host_role_bit == $past(writedata[host_event_pkg::HOST_ROLE_BIT]))
    else $error("role bit not written");

  role_keep_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R9
    !(write && ack && byteenable[0] && hit(address, 0, host_event_pkg::ROLE_OFS)) |=> $stable(host_role_bit))
    else $error("role bit changed without a write");

  enable_write_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R14
    (write && ack && byteenable[0] && hit(address, 0, host_event_pkg::ENABLE_OFS))
    |=> enable[0] == ($past(writedata[7:0]) & host_event_pkg::EVENT_MASK))
    else $error("enable write wrong");

  enable_write1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R14
    (NUM_PORTS == 2 && write && ack && byteenable[0] && hit(address, 1, host_event_pkg::ENABLE_OFS))
    |=> enable[NUM_PORTS-1] == ($past(writedata[7:0]) & host_event_pkg::EVENT_MASK))
    else $error("second port enable write wrong");

  lane_guard_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (write && !byteenable[0]) |=> ($stable(enable[0]) && $stable(host_role_bit)))
    else $error("write without byte lane took effect");

  host_clear0_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (write && ack && byteenable[0] && host_role_bit && hit(address, 0, host_event_pkg::STATUS_OFS)
    && writedata[host_event_pkg::ATTACH_BIT] && !cable_attach_event[0])
    |=> !status[0][host_event_pkg::ATTACH_BIT])
    else $error("attach bit not cleared by bus write");

  host_clear1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R1
    (NUM_PORTS == 2 && write && ack && byteenable[0] && host_role_bit
    && hit(address, 1, host_event_pkg::STATUS_OFS) && writedata[host_event_pkg::DETACH_BIT]
    && !cable_detach_event[NUM_PORTS-1]) |=> !status[NUM_PORTS-1][host_event_pkg::DETACH_BIT])
    else $error("detach bit not cleared by bus write");

  irq_port1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R13
    (|(status[NUM_PORTS-1] & enable[NUM_PORTS-1])) |-> !irq_out_n)
    else $error("interrupt not asserted for second port");

  speed_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R7
    !(bus_reset_active[0] && status[0][host_event_pkg::GOOD_CHIRP_BIT]) |=> $stable(port_speed_field[0]))
    else $error("speed changed without chirp in bus reset");

  speed_hold1_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // R7
    !(bus_reset_active[NUM_PORTS-1] && status[NUM_PORTS-1][host_event_pkg::GOOD_CHIRP_BIT])
    |=> $stable(port_speed_field[NUM_PORTS-1]))
    else $error("second port speed changed without chirp");

endmodule

// File: test/usb_dev_model.sv
// Model of the USB device attached on the host port cable
`timescale 1ns/1ns
module usb_dev_model #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic clk,
  output logic [NUM_PORTS-1:0] cable_attach_event,
  output logic [NUM_PORTS-1:0] cable_detach_event,
  output logic [NUM_PORTS-1:0] remote_wakeup_event,
  output logic [NUM_PORTS-1:0] good_chirp_event,
  output logic [NUM_PORTS-1:0] bad_chirp_event,
  output logic [NUM_PORTS-1:0] bus_reset_active
);
  logic [NUM_PORTS-1:0][4:0] ev = '0;

  // Line events share the status bit positions
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      cable_attach_event[p] = ev[p][4];
      cable_detach_event[p] = ev[p][3];
      remote_wakeup_event[p] = ev[p][2];
      good_chirp_event[p] = ev[p][1];
      bad_chirp_event[p] = ev[p][0];
    end
  end

  initial begin
    bus_reset_active = '0;
  end

  // One-cycle event, started just after a rising edge
  task automatic emit(input int port, input int pos);
    ev[port][pos] <= 1'b1;
    @(posedge clk);
    ev[port][pos] <= 1'b0;
  endtask

  task automatic hold_reset(input logic [NUM_PORTS-1:0] lvl);
    bus_reset_active <= lvl;
  endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the host port event status block
`timescale 1ns/1ns
module testbench;
  localparam logic [9:0] st0 = host_event_pkg::STATUS_OFS;
  localparam logic [9:0] en0 = host_event_pkg::ENABLE_OFS;
  localparam logic [9:0] st1 = host_event_pkg::STATUS_OFS + host_event_pkg::PORT_STEP;
  localparam logic [9:0] en1 = host_event_pkg::ENABLE_OFS + host_event_pkg::PORT_STEP;
  localparam logic [9:0] sp0 = host_event_pkg::SPEED_OFS;
  localparam logic [9:0] sp1 = host_event_pkg::SPEED_OFS + host_event_pkg::PORT_STEP;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] att, det, wak, gch, bch, brs;
  logic [1:0][1:0] speed;
  logic role;
  logic irq_out_n;
  logic [31:0] rd;
  int n_errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  host_port_event_status #(.NUM_PORTS(2), .ADDR_W(10)) i_dut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cable_attach_event(att), .cable_detach_event(det), .remote_wakeup_event(wak),
    .good_chirp_event(gch), .bad_chirp_event(bch), .bus_reset_active(brs), .port_speed_field(speed),
    .host_role_bit(role), .irq_out_n(irq_out_n));

  usb_dev_model #(.NUM_PORTS(2)) i_dev (.clk(clk), .cable_attach_event(att), .cable_detach_event(det),
    .remote_wakeup_event(wak), .good_chirp_event(gch), .bad_chirp_event(bch), .bus_reset_active(brs));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Avalon cycle; one idle edge follows the release
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      results();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rd, {24'h000000, e}, "register read");
  endtask

  task automatic irq_chk(input logic e);
    #1;
    check({31'h00000000, irq_out_n}, {31'h00000000, e}, "irq_out_n");
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_gating();
    check({28'h0000000, speed}, 32'h00000005, "speed after reset");
    irq_chk(1'b1);
    i_dev.emit(0, 4);
    rd_chk(st0, 8'h00);
    wr(st0, 8'h1F);
    wr(host_event_pkg::ROLE_OFS, 8'h01);
    check({31'h00000000, role}, 32'h00000001, "role bit");
    rd_chk(st0, 8'h10);
    wr(st0, 8'h00);
    rd_chk(st0, 8'h10);
    wr(st0, 8'h10);
    rd_chk(st0, 8'h00);
  endtask

  task automatic t_events();
    for (int b = 0; b < 5; b++) begin
      i_dev.emit(1, b);
      rd_chk(st1, 8'h01 << b);
      wr(st1, 8'hE0);
      rd_chk(st1, 8'h01 << b);
      wr(st1, 8'h01 << b);
      rd_chk(st1, 8'h00);
    end
    rd_chk(st0, 8'h00);
  endtask

  task automatic t_irq();
    wr(en0, 8'h04);
    i_dev.emit(0, 2);
    irq_chk(1'b0);
    wr(st0, 8'h04);
    irq_chk(1'b1);
    wr(en0, 8'h00);
    wr(en1, 8'hE8);
    rd_chk(en1, 8'h08);
    i_dev.emit(1, 3);
    irq_chk(1'b0);
    wr(en1, 8'h00);
    irq_chk(1'b1);
    wr(en1, 8'h08);
    irq_chk(1'b0);
    byteenable <= 4'h0;
    wr(st1, 8'h08);
    byteenable <= 4'hF;
    irq_chk(1'b0);
    wr(st1, 8'h08);
    irq_chk(1'b1);
    fork
      wr(st1, 8'h08);
      begin
        @(posedge clk);
        i_dev.emit(1, 3);
      end
    join
    irq_chk(1'b0);
    rd_chk(st1, 8'h08);
    wr(st1, 8'h08);
    wr(en1, 8'h00);
  endtask

  task automatic t_speed();
    i_dev.emit(0, 1);
    i_dev.hold_reset(2'b11);
    repeat (2) @(posedge clk);
    check({30'h00000000, speed[0]}, 32'h00000000, "port0 speed");
    check({30'h00000000, speed[1]}, 32'h00000001, "port1 speed");
    rd_chk(sp0, 8'h00);
    rd_chk(sp1, 8'h01);
    i_dev.hold_reset(2'b00);
    i_dev.emit(0, 3);
    rd_chk(st0, 8'h0A);
    wr(st0, 8'h0A);
    rd_chk(st0, 8'h00);
    wr(10'h3F0, 8'hFF);
    rd_chk(10'h3F0, 8'h00);
  endtask

  task automatic t_reset();
    wr(en1, 8'h02);
    i_dev.emit(0, 4);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h00000000, role}, 32'h00000000, "role in reset");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({28'h0000000, speed}, 32'h00000005, "speed after second reset");
    irq_chk(1'b1);
    rd_chk(en1, 8'h00);
    rd_chk(host_event_pkg::ROLE_OFS, 8'h00);
    wr(host_event_pkg::ROLE_OFS, 8'h01);
    rd_chk(st0, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_gating();
    t_events();
    t_irq();
    t_speed();
    t_reset();
    results();
  end
endmodule
